// ### design/load_limit_map.vh
// constants for the load limit relay monitor: register offsets, fields, reset values, timing
// assumes a 20 MHz APB clock and loads already scaled to whole percent of the final value
`ifndef LOAD_LIMIT_MAP_VH
`define LOAD_LIMIT_MAP_VH
`define CLK_HZ 20000000
`define TICK_MS 1
`define MS_CYCLES (`CLK_HZ / 1000 * `TICK_MS)
`define USAGE_TICK_MS 3600
`define USAGE_CYCLES (`CLK_HZ / 1000 * `USAGE_TICK_MS)
`define DELAY_MAX_MS 13'h1388
`define RUN_THRESH_PCT 10'h00a
`define NUM_SETS 8
`define SET_WORDS 13
`define CFG_WORD 12
`define STORE_WORDS 104
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STAT 12'h008
`define REG_IRQ_MASK 12'h00c
`define REG_BUDGET_A 12'h010
`define REG_BUDGET_B 12'h014
`define REG_START_A 12'h018
`define REG_START_B 12'h01c
`define REG_USAGE_A 12'h020
`define REG_USAGE_B 12'h024
`define REG_CONSUMED_A 12'h028
`define REG_CONSUMED_B 12'h02c
`define REG_SET_BASE 12'h100
`define SET_STRIDE_SH 6
`define CTRL_START 0
`define CTRL_COMMIT 1
`define CTRL_EXIT 2
`define CTRL_REC_SAVE 3
`define CTRL_SEL_LSB 4
`define PT_VAL_MSB 9
`define PT_REL_LSB 10
`define PT_REL_MSB 15
`define PT_DLY_LSB 16
`define PT_DLY_MSB 28
`define IRQ_TRIP 0
`define IRQ_COMMIT 1
`define IRQ_BUDGET 2
`define WORD_RESET 29'h0000_0000
`endif

// ### design/load_limit_relay_monitor.v
// limit supervision for two hoist loads with eight limit sets, relays and usage recorder
// assumes an APB master on pclk; load inputs are synchronous and in whole percent
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "load_limit_map.vh"
module load_limit_relay_monitor #(
  parameter [31:0] MS_CYCLES = `MS_CYCLES,
  parameter [31:0] USAGE_CYCLES = `USAGE_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire [9:0] logic_unit_one_load_a,
  input wire [9:0] logic_unit_one_load_b,
  input wire [9:0] logic_unit_two_load_a,
  input wire [9:0] logic_unit_two_load_b,
  input wire [7:0] dig_in,
  output reg [5:0] limit_relay_contact_open,
  output wire irq
);

  reg [28:0] stage_q [0:`STORE_WORDS-1];
  reg [28:0] act_q [0:`STORE_WORDS-1];
  reg editing_q;
  reg [2:0] sel_q;
  reg [2:0] used_set_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  // budgets in hours: staged by software, taken over on a recorder save
  reg [15:0] budget_stage_a_q;
  reg [15:0] budget_stage_b_q;
  reg [15:0] budget_a_q;
  reg [15:0] budget_b_q;
  // start usage staged in hours until a recorder save
  reg [15:0] start_a_q;
  reg [15:0] start_b_q;
  // usage in milli-hours; tick counters for the ms and usage time bases
  reg [31:0] usage_a_q;
  reg [31:0] usage_b_q;
  reg [31:0] ms_cnt_q;
  reg [31:0] usage_cnt_q;
  reg [12:0] dly_cnt_q [0:5];
  // one loop index per process so no variable has two drivers
  integer i;
  integer pt_i;
  integer tm_i;
  integer wd_i;

  // apb decode; one setup and one access cycle, read data captured at setup
  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire in_sets = (paddr >= `REG_SET_BASE) &&
                 (paddr < `REG_SET_BASE + (12'h008 << `SET_STRIDE_SH));
  wire [11:0] set_off = paddr - `REG_SET_BASE;
  wire [2:0] set_no = set_off[8:6];
  wire [3:0] word_no = set_off[5:2];
  wire set_ok = in_sets && (word_no < `SET_WORDS) && (paddr[1:0] == 2'b00);
  // staging index: set times thirteen words plus word, same layout as the active store
  wire [6:0] set_idx = {1'b0, set_no, 3'b000} + {2'b00, set_no, 2'b00}
                       + {4'b0000, set_no} + {3'b000, word_no};
  assign pready = 1'b1;

  // active set base index: set times thirteen words
  wire [6:0] base = {1'b0, used_set_q, 3'b000} + {2'b00, used_set_q, 2'b00}
                    + {4'b0000, used_set_q};
  wire [28:0] cfg_w = act_q[base + `CFG_WORD];
  // per-set option gates switching by one chosen digital input
  wire sw_enable = ~cfg_w[0] | dig_in[cfg_w[3:1]];

  // sum and difference on the percent scale, either logic unit can trip
  wire signed [10:0] u1a = {logic_unit_one_load_a[9], logic_unit_one_load_a};
  wire signed [10:0] u1b = {logic_unit_one_load_b[9], logic_unit_one_load_b};
  wire signed [10:0] u2a = {logic_unit_two_load_a[9], logic_unit_two_load_a};
  wire signed [10:0] u2b = {logic_unit_two_load_b[9], logic_unit_two_load_b};
  wire signed [10:0] u1s = u1a + u1b;
  wire signed [10:0] u2s = u2a + u2b;
  wire signed [10:0] u1d0 = u1a - u1b;
  wire signed [10:0] u2d0 = u2a - u2b;
  wire signed [10:0] u1d = u1d0[10] ? -u1d0 : u1d0;
  wire signed [10:0] u2d = u2d0[10] ? -u2d0 : u2d0;

  // conditions: 0 a over,1 a under,2 b over,3 b under,4 sum over,5 diff over
  reg [5:0] dly_cond, imm_cond;
  reg signed [10:0] s1, s2, thr_d, thr_i;
  always @*
  begin
    dly_cond = 6'b00_0000;
    imm_cond = 6'b00_0000;
    s1 = 11'sd0;
    s2 = 11'sd0;
    thr_d = 11'sd0;
    thr_i = 11'sd0;
    for (i = 0; i < 6; i = i + 1)
    begin
      case (i)
        0, 1: begin s1 = u1a; s2 = u2a; end
        2, 3: begin s1 = u1b; s2 = u2b; end
        4: begin s1 = u1s; s2 = u2s; end
        default: begin s1 = u1d; s2 = u2d; end
      endcase
      thr_d = {act_q[base + i][`PT_VAL_MSB], act_q[base + i][`PT_VAL_MSB:0]};
      thr_i = {act_q[base + i + 6][`PT_VAL_MSB], act_q[base + i + 6][`PT_VAL_MSB:0]};
      if (i == 1 || i == 3)
      begin
        dly_cond[i] = (s1 < thr_d) | (s2 < thr_d);
        imm_cond[i] = (s1 < thr_i) | (s2 < thr_i);
      end
      else
      begin
        dly_cond[i] = (s1 > thr_d) | (s2 > thr_d);
        imm_cond[i] = (s1 > thr_i) | (s2 > thr_i);
      end
    end
  end

  // delay limit per point, clamped to the five second ceiling
  reg [5:0] dly_trip;
  reg [12:0] dly_lim;
  reg [5:0] relay_d;
  always @*
  begin
    dly_trip = 6'b00_0000;
    dly_lim = 13'h0000;
    relay_d = 6'b00_0000;
    for (pt_i = 0; pt_i < 6; pt_i = pt_i + 1)
    begin
      dly_lim = act_q[base + pt_i][`PT_DLY_MSB:`PT_DLY_LSB];
      if (dly_lim > `DELAY_MAX_MS)
        dly_lim = `DELAY_MAX_MS;
      dly_trip[pt_i] = sw_enable & dly_cond[pt_i] & (dly_cnt_q[pt_i] >= dly_lim);
      // a delayed point only reaches its contacts once its timer has run out
      if (dly_trip[pt_i])
        relay_d = relay_d | act_q[base + pt_i][`PT_REL_MSB:`PT_REL_LSB];
      // immediate points bypass the timers entirely
      if (sw_enable & imm_cond[pt_i])
        relay_d = relay_d | act_q[base + pt_i + 6][`PT_REL_MSB:`PT_REL_LSB];
    end
  end

  wire ms_tick = (ms_cnt_q == MS_CYCLES - 32'h0000_0001);
  wire usage_tick = (usage_cnt_q == USAGE_CYCLES - 32'h0000_0001);

  // delay timers run on millisecond ticks and clear when the signal returns
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ms_cnt_q <= 32'h0000_0000;
      for (tm_i = 0; tm_i < 6; tm_i = tm_i + 1)
        dly_cnt_q[tm_i] <= 13'h0000;
    end
    else
    begin
      ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
      // timers saturate at the ceiling so a long overload never wraps back to zero
      for (tm_i = 0; tm_i < 6; tm_i = tm_i + 1)
        if (!(sw_enable & dly_cond[tm_i]))
          dly_cnt_q[tm_i] <= 13'h0000;
        else if (ms_tick && dly_cnt_q[tm_i] < `DELAY_MAX_MS)
          dly_cnt_q[tm_i] <= dly_cnt_q[tm_i] + 13'h0001;
    end
  end

  // recorder: hoist a from sensor 1a, hoist b from sensor 1b of unit one
  wire run_a = ($signed(logic_unit_one_load_a) > $signed(`RUN_THRESH_PCT));
  wire run_b = ($signed(logic_unit_one_load_b) > $signed(`RUN_THRESH_PCT));
  wire [47:0] budget_a_mh = budget_a_q * 32'd1000;
  wire [47:0] budget_b_mh = budget_b_q * 32'd1000;
  wire over_budget = ((budget_a_q != 16'h0000) && ({16'h0000, usage_a_q} >= budget_a_mh)) ||
                     ((budget_b_q != 16'h0000) && ({16'h0000, usage_b_q} >= budget_b_mh));
  // consumed usage in hundredths of a percent: milli-hours times ten over hours
  wire [35:0] cons_a = (budget_a_q == 16'h0000) ? 36'h0_0000_0000 :
                       (usage_a_q * 36'd10) / budget_a_q;
  wire [35:0] cons_b = (budget_b_q == 16'h0000) ? 36'h0_0000_0000 :
                       (usage_b_q * 36'd10) / budget_b_q;
  wire rec_save = wr_acc && paddr == `REG_CTRL && pwdata[`CTRL_REC_SAVE];

  // usage counts in milli-hours, only while the hoist unit runs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      usage_cnt_q <= 32'h0000_0000;
      usage_a_q <= 32'h0000_0000;
      usage_b_q <= 32'h0000_0000;
      budget_a_q <= 16'h0000;
      budget_b_q <= 16'h0000;
    end
    else
    begin
      usage_cnt_q <= usage_tick ? 32'h0000_0000 : usage_cnt_q + 32'h0000_0001;
      if (rec_save)
      begin
        budget_a_q <= budget_stage_a_q;
        budget_b_q <= budget_stage_b_q;
        usage_a_q <= start_a_q * 32'd1000;
        usage_b_q <= start_b_q * 32'd1000;
      end
      else if (usage_tick)
      begin
        if (run_a)
          usage_a_q <= usage_a_q + 32'h0000_0001;
        if (run_b)
          usage_b_q <= usage_b_q + 32'h0000_0001;
      end
    end
  end

  // control writes, limit storage, staging and commit
  wire ctrl_wr = wr_acc && paddr == `REG_CTRL;
  wire do_load = ctrl_wr && pwdata[`CTRL_START];
  wire do_commit = ctrl_wr && pwdata[`CTRL_COMMIT];
  wire do_exit = ctrl_wr && pwdata[`CTRL_EXIT];
  wire relay_rise = |(relay_d & ~limit_relay_contact_open);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // all-zero words carry no relay allocation, so nothing opens after reset
      for (wd_i = 0; wd_i < `STORE_WORDS; wd_i = wd_i + 1)
      begin
        stage_q[wd_i] <= `WORD_RESET;
        act_q[wd_i] <= `WORD_RESET;
      end
      editing_q <= 1'b0;
      sel_q <= 3'b000;
      used_set_q <= 3'b000;
      budget_stage_a_q <= 16'h0000;
      budget_stage_b_q <= 16'h0000;
      start_a_q <= 16'h0000;
      start_b_q <= 16'h0000;
      irq_mask_q <= 3'b000;
    end
    else
    begin
      if (do_commit)
      begin
        // whole store is copied in one edge so supervision never sees a half-new set
        for (wd_i = 0; wd_i < `STORE_WORDS; wd_i = wd_i + 1)
          act_q[wd_i] <= stage_q[wd_i];
        used_set_q <= pwdata[`CTRL_SEL_LSB+2:`CTRL_SEL_LSB];
        editing_q <= 1'b0;
      end
      else if (do_load || do_exit)
      begin
        // start and exit both refresh the staging copy from the active store
        for (wd_i = 0; wd_i < `STORE_WORDS; wd_i = wd_i + 1)
          stage_q[wd_i] <= act_q[wd_i];
        editing_q <= do_load;
      end
      else if (wr_acc && set_ok && editing_q)
        stage_q[set_idx] <= pwdata[28:0];
      if (ctrl_wr)
        sel_q <= pwdata[`CTRL_SEL_LSB+2:`CTRL_SEL_LSB];
      if (wr_acc && paddr == `REG_IRQ_MASK)
        irq_mask_q <= pwdata[2:0];
      if (wr_acc && paddr == `REG_BUDGET_A)
        budget_stage_a_q <= pwdata[15:0];
      if (wr_acc && paddr == `REG_BUDGET_B)
        budget_stage_b_q <= pwdata[15:0];
      if (wr_acc && paddr == `REG_START_A)
        start_a_q <= pwdata[15:0];
      if (wr_acc && paddr == `REG_START_B)
        start_b_q <= pwdata[15:0];
    end
  end

  // relay outputs registered so a comparator glitch never reaches a contact
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      limit_relay_contact_open <= 6'b00_0000;
    else
      limit_relay_contact_open <= relay_d;
  end

  // sticky events; a read clears them but an event in the same cycle wins
  wire stat_rd = psel && penable && !pwrite && paddr == `REG_IRQ_STAT;
  wire [2:0] irq_ev = {over_budget, do_commit, relay_rise};
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_q <= 3'b000;
    else
      irq_stat_q <= (stat_rd ? 3'b000 : irq_stat_q) | irq_ev;
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // read data captured in the setup cycle, presented in the access cycle
  reg [31:0] rd_d;
  reg err_d;
  always @*
  begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr)
      `REG_CTRL: rd_d = {25'h000_0000, sel_q, 4'h0};
      // status: bit 0 editing, 6:4 active set, 13:8 relays, 14 run a, 15 run b
      `REG_STATUS: rd_d = {16'h0000, run_b, run_a, limit_relay_contact_open, 1'b0,
                           used_set_q, 3'b000, editing_q};
      // an event in the setup cycle is reported here, else the clear would lose it
      `REG_IRQ_STAT: rd_d = {29'h0000_0000, irq_stat_q | irq_ev};
      `REG_IRQ_MASK: rd_d = {29'h0000_0000, irq_mask_q};
      `REG_BUDGET_A: rd_d = {16'h0000, budget_stage_a_q};
      `REG_BUDGET_B: rd_d = {16'h0000, budget_stage_b_q};
      `REG_START_A: rd_d = {16'h0000, start_a_q};
      `REG_START_B: rd_d = {16'h0000, start_b_q};
      `REG_USAGE_A: rd_d = usage_a_q;
      `REG_USAGE_B: rd_d = usage_b_q;
      `REG_CONSUMED_A: rd_d = cons_a[31:0];
      `REG_CONSUMED_B: rd_d = cons_b[31:0];
      default:
      begin
        if (set_ok)
          rd_d = {3'b000, stage_q[set_idx]};
        else
          err_d = 1'b1;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= rd_d;
      pslverr <= err_d;
    end
  end

endmodule // load_limit_relay_monitor
`default_nettype wire

// ### verification/load_limit_checker_properties.sv
// checker for the load limit monitor: apb answers, edit state, relay and irq idle
// assumes it is bound onto the monitor top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
`include "load_limit_map.vh"
module load_limit_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [5:0] limit_relay_contact_open,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic edit_q, cm_q;
  logic [2:0] act_q, mask_q;
  // decoded accesses; set words past 12 and the gaps are unmapped
  wire acc = psel && penable;
  wire wr_ctrl = acc && pwrite && paddr == `REG_CTRL;
  wire rd_stat = acc && !pwrite && paddr == `REG_STATUS;
  wire in_set = paddr >= `REG_SET_BASE;
  wire bad = (paddr >= 12'h030 && !in_set) || paddr >= 12'h300 ||
             (in_set && paddr[5:0] >= 6'h34) || paddr[1:0] != 2'b00;
  // mirror of edit state and active set; commit outranks start and exit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      edit_q <= 1'b0;
      cm_q <= 1'b0;
      act_q <= 3'h0;
      mask_q <= 3'h0;
    end
    else
    begin
      if (acc && pwrite && paddr == `REG_IRQ_MASK)
        mask_q <= pwdata[2:0];
      if (wr_ctrl && pwdata[1])
      begin
        edit_q <= 1'b0;
        cm_q <= 1'b1;
        act_q <= pwdata[6:4];
      end
      else if (wr_ctrl && (pwdata[0] || pwdata[2]))
        edit_q <= pwdata[0];
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_ready;
    s_access |-> pready;
  endproperty
  property p_err_zero;
    acc && !pwrite && pslverr |-> prdata == 32'h0;
  endproperty
  property p_unmapped;
    s_access |-> pslverr == bad;
  endproperty
  property p_hold;
    s_setup ##1 s_access |=> $stable(prdata);
  endproperty
  // nothing can open before the first commit: all active words reset to zero
  property p_idle_relay;
    !cm_q |-> limit_relay_contact_open == 6'h00;
  endproperty
  property p_irq_mask;
    mask_q == 3'h0 |-> !irq;
  endproperty
  property p_edit;
    rd_stat |-> prdata[0] == edit_q;
  endproperty
  property p_set;
    rd_stat |-> prdata[6:4] == act_q;
  endproperty
  // a newly opened contact raises the interrupt when its event is unmasked
  property p_trip_irq;
    mask_q[0] && |(limit_relay_contact_open & ~$past(limit_relay_contact_open)) |-> irq;
  endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
  a_unmapped: assert property (p_unmapped) else $error("slave error wrong for address");
  a_hold: assert property (p_hold) else $error("read data moved after access");
  a_idle_relay: assert property (p_idle_relay) else $error("relay open before commit");
  a_irq_mask: assert property (p_irq_mask) else $error("irq with mask clear");
  a_edit: assert property (p_edit) else $error("edit flag wrong");
  a_set: assert property (p_set) else $error("active set wrong");
  a_trip_irq: assert property (p_trip_irq) else $error("relay opened without irq");
endmodule // load_limit_checker
bind load_limit_relay_monitor load_limit_checker u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .limit_relay_contact_open, .irq);
`default_nettype wire

// ### verification/hoist_load_model.sv
// load source for the two redundant logic units of hoists a and b
// assumes the bench sets target loads and which units report them
`timescale 1ns/100ps
`default_nettype none
module hoist_load_model (
  input wire logic pclk,
  input wire logic [9:0] load_a,
  input wire logic [9:0] load_b,
  input wire logic [1:0] live,
  output logic [9:0] one_a,
  output logic [9:0] one_b,
  output logic [9:0] two_a,
  output logic [9:0] two_b
);
  // each unit measures on its own, so one may see a crossing the other misses
  always_ff @(posedge pclk)
  begin
    one_a <= live[0] ? load_a : 10'h000;
    one_b <= live[0] ? load_b : 10'h000;
    two_a <= live[1] ? load_a : 10'h000;
    two_b <= live[1] ? load_b : 10'h000;
  end
endmodule // hoist_load_model
`default_nettype wire

// ### verification/load_limit_relay_monitor_tb_top.sv
// bench for the load limit monitor: apb row table, then relay and recorder cases
// assumes the checker is bound and the load model drives the unit channels
`timescale 1ns/100ps
`default_nettype none
`include "load_limit_map.vh"
module load_limit_relay_monitor_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] la, lb, one_a, one_b, two_a, two_b;
  logic [1:0] live;
  logic [7:0] dig_in;
  logic [5:0] relay;
  int num_errors, tests_run;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  row_t rows [15];
  hoist_load_model u_load (.pclk(pclk), .load_a(la), .load_b(lb), .live(live),
    .one_a(one_a), .one_b(one_b), .two_a(two_a), .two_b(two_b));
  // short tick counts keep the delay and usage runs brief
  load_limit_relay_monitor #(.MS_CYCLES(32'h4), .USAGE_CYCLES(32'h8)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .logic_unit_one_load_a(one_a), .logic_unit_one_load_b(one_b),
    .logic_unit_two_load_a(two_a), .logic_unit_two_load_b(two_b), .dig_in(dig_in),
    .limit_relay_contact_open(relay), .irq(irq));
  // 20 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // one apb transfer; waits on pready as long as it takes, the watchdog bounds it
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
  begin
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge: the next transfer never re-raises psel in this time step
    @(posedge pclk);
  end
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
  begin
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  end
  endtask
  task ld(input logic [9:0] a, input logic [9:0] b, input logic [1:0] u, input int n);
  begin
    la <= a;
    lb <= b;
    live <= u;
    repeat (n) @(posedge pclk);
  end
  endtask
  task rel(input logic [5:0] m, input logic [5:0] e);
  begin
    chk({26'h0, relay & m}, {26'h0, e});
  end
  endtask
  task stop_test;
  begin
    $display("mismatches %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // main sequence: rows stage set 0, then hand-written relay, edit and recorder cases
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, la, lb, dig_in} = '0;
    live = 2'h3;
    num_errors = 0;
    tests_run = 0;
    rows = '{{1'b0, `REG_STATUS, 32'h0, 32'h0}, {1'b1, 12'h118, 32'h464, 32'h0},
      {1'b0, 12'h118, 32'h0, 32'h0}, {1'b1, `REG_CTRL, 32'h1, 32'h0},
      {1'b0, `REG_STATUS, 32'h0, 32'h1}, {1'b1, 12'h118, 32'h464, 32'h0},
      {1'b1, 12'h100, 32'h0004_0832, 32'h0}, {1'b1, 12'h128, 32'h496, 32'h0},
      {1'b1, 12'h12c, 32'h101e, 32'h0}, {1'b0, 12'h118, 32'h0, 32'h464},
      {1'b1, `REG_IRQ_MASK, 32'h3, 32'h0}, {1'b0, `REG_IRQ_MASK, 32'h0, 32'h3},
      {1'b0, 12'h030, 32'h0, 32'h0}, {1'b1, `REG_CTRL, 32'h2, 32'h0},
      {1'b0, `REG_STATUS, 32'h0, 32'h0}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rel(6'h3f, 6'h00);
    chk({31'h0, irq}, 32'h0);
    foreach (rows[i])
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      else rdc(rows[i].a, rows[i].e);
    apb(1'b0, `REG_IRQ_STAT, 32'h0);
    chk(rd & 32'h3, 32'h2);
    // unit two alone: immediate points open at once, delayed one later
    ld(10'h06e, 10'h000, 2'b10, 3);
    rel(6'h3f, 6'h05);
    ld(10'h06e, 10'h000, 2'b10, 22);
    rel(6'h3f, 6'h07);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `REG_IRQ_STAT, 32'h0);
    chk(rd & 32'h3, 32'h1);
    chk({31'h0, irq}, 32'h0);
    ld(10'h000, 10'h000, 2'b11, 3);
    rel(6'h3f, 6'h00);
    ld(10'h064, 10'h000, 2'b01, 3);
    rel(6'h01, 6'h00);
    ld(10'h065, 10'h000, 2'b01, 3);
    rel(6'h01, 6'h01);
    ld(10'h050, 10'h050, 2'b11, 3);
    rel(6'h05, 6'h01);
    // a short excursion must not open the delayed contact
    ld(10'h000, 10'h000, 2'b11, 3);
    ld(10'h03c, 10'h03c, 2'b11, 5);
    ld(10'h000, 10'h000, 2'b11, 20);
    rel(6'h02, 6'h00);
    ld(10'h03c, 10'h03c, 2'b11, 24);
    rel(6'h02, 6'h02);
    // exit without commit leaves the active limit in force
    apb(1'b1, `REG_CTRL, 32'h1);
    apb(1'b1, 12'h118, 32'h4c8);
    rdc(12'h118, 32'h4c8);
    apb(1'b1, `REG_CTRL, 32'h4);
    rdc(12'h118, 32'h464);
    ld(10'h096, 10'h000, 2'b01, 3);
    rel(6'h01, 6'h01);
    // switching gated by digital input 7
    apb(1'b1, `REG_CTRL, 32'h1);
    apb(1'b1, 12'h130, 32'hf);
    apb(1'b1, `REG_CTRL, 32'h2);
    ld(10'h06e, 10'h000, 2'b01, 3);
    rel(6'h3f, 6'h00);
    dig_in <= 8'h80;
    ld(10'h06e, 10'h000, 2'b01, 3);
    rel(6'h01, 6'h01);
    // committing set 5 hands over its own limits: only its immediate a point
    apb(1'b1, `REG_CTRL, 32'h1);
    apb(1'b1, 12'h258, 32'h464);
    apb(1'b1, `REG_CTRL, 32'h52);
    ld(10'h000, 10'h000, 2'b11, 2);
    rdc(`REG_STATUS, 32'h50);
    ld(10'h06e, 10'h000, 2'b11, 3);
    rel(6'h3f, 6'h01);
    // recorder: save, run only on unit one loads, consumed ratio
    apb(1'b1, `REG_BUDGET_A, 32'h1);
    apb(1'b1, `REG_START_A, 32'h2);
    ld(10'h000, 10'h000, 2'b11, 1);
    apb(1'b1, `REG_CTRL, 32'h8);
    rdc(`REG_USAGE_A, 32'h7d0);
    rdc(`REG_CONSUMED_A, 32'h4e20);
    ld(10'h014, 10'h014, 2'b10, 40);
    rdc(`REG_USAGE_A, 32'h7d0);
    ld(10'h014, 10'h014, 2'b01, 2);
    rdc(`REG_STATUS, 32'hc050);
    ld(10'h014, 10'h014, 2'b01, 76);
    ld(10'h000, 10'h000, 2'b11, 3);
    apb(1'b0, `REG_USAGE_A, 32'h0);
    chk({31'h0, rd >= 32'h7d8 && rd <= 32'h7dc}, 32'h1);
    // reset in mid-run: contacts close, set 0 active, recorder cleared
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    rel(6'h3f, 6'h00);
    chk({31'h0, irq}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`REG_STATUS, 32'h0);
    rdc(`REG_USAGE_A, 32'h0);
    stop_test();
  end
  // watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    #(20000 * 50);
    num_errors++;
    stop_test();
  end
endmodule // load_limit_relay_monitor_tb_top
`default_nettype wire
